//--- hdl/umon_consts.vh
// Constants for the upset monitor suite: offsets, fields, reset values and counts
`ifndef UMON_CONSTS_VH
`define UMON_CONSTS_VH

// ----------------------------------------
// Register offsets (management address)
// ----------------------------------------
`define UMON_ADDR_IRQ_MASK    9'h1D7
`define UMON_ADDR_FAULT_STAT  9'h1D8
`define UMON_ADDR_TEMP_LO     9'h1E8
`define UMON_ADDR_TEMP_HI     9'h1EA
`define UMON_ADDR_ECC_CTRL    9'h1EE

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UMON_PLL_MASK_BIT     11
`define UMON_ST_MASK_LO       0
`define UMON_ST_MASK_HI       1
`define UMON_ST_STAT_LO       2
`define UMON_ST_STAT_HI       11
`define UMON_ECC_STAT_LO      12
`define UMON_ECC_STAT_HI      15
`define UMON_ECC_EN_LO        7
`define UMON_ECC_EN_HI        9
`define UMON_RECOVER_BIT      15
`define UMON_THERM_MASK_BIT   12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UMON_MASK_RESET       16'h0800
`define UMON_ECC_CTRL_RESET   16'h0000
`define UMON_STAT_RESET       16'h0000
`define UMON_SUM_RESET        16'h0000

// ----------------------------------------
// Timing and sizing
// ----------------------------------------
`define UMON_CFG_WORDS        4
`define UMON_LOCK_WIN_RESET   8'h04
`define UMON_RELOCK_RESET     8'h10
`define UMON_THERM_PCT_RESET  8'h0A

`endif

//--- hdl/umon_lock_detect.v
// PLL lock detector: window check on phase difference and relock count
`timescale 1ns/100ps
module umon_lock_detect (
   // Clock and reset
   input  wire        mclk,
   input  wire        resetn,
   // Phase measurement, already synchronised
   input  wire [7:0]  phase_diff,
   // Programmable window and relock cycles
   input  wire [7:0]  delay_window,
   input  wire [7:0]  relock_cycles,
   // Lock indication
   output reg         locked_reg
);

   reg  [7:0]  relock_cnt_reg;
   wire        out_of_window;

   assign out_of_window = (phase_diff > delay_window);

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         locked_reg     <= 1'b0;
         relock_cnt_reg <= 8'h00;
      end else if (out_of_window) begin
         locked_reg     <= 1'b0; // R13
         relock_cnt_reg <= 8'h00;
      end else if (!locked_reg) begin
         if (relock_cnt_reg >= relock_cycles) begin
            locked_reg <= 1'b1; // R14
         end else begin
            relock_cnt_reg <= relock_cnt_reg + 8'h01; // R14
         end
      end
   end

endmodule

//--- hdl/umon_top.v
// Upset monitor suite: state, configuration, thermal and PLL lock fault monitors
//
// Overview of operation
// [R01] Illegal coding-state transition flags upset, drives state fault pin, sets status.
// [R02] With self-recovery set, a state error pulses internal reset; pin asserts anyway.
// [R03] Mask bits 1:0 of the status register suppress the state fault pin.
// [R04] ECC detect or correct events raise interrupt, status in bits 15:12.
// [R05] ECC protection is enabled by control register bits 9:7.
// [R06] At lockout rise, checksum all config words in order; store golden. A checksum started at reset is dropped next cycle.
// [R07] While locked out, recompute running sum; mismatch asserts configuration fault.
// [R08] Lockout deassertion clears golden sum and stops comparison.
// [R09] Self-recovery restores config defaults incl. straps; fault pin asserts anyway.
// [R10] Programmable percent threshold on temperature jump raises thermal interrupt.
// [R11] Temperature reading is readable at offset 0x1E8; threshold and jump flag at 0x1EA.
// [R12] PLL out of lock raises interrupt at once, checked continuously.
// [R13] Lock drops when phase difference exceeds programmable window.
// [R14] After realignment, count programmable reference cycles before relocking.
// [R15] Software clears mask bit 11 of 0x1D7 to receive PLL interrupts.
// [R16] PLL interrupt appears only on a pin given the upset interrupt function.
// [R17] No comparison until first golden computation has fully completed.
// [R18] All fault interrupt outputs are active low, low while pending and unmasked.
`timescale 1ns/100ps
`include "umon_consts.vh"
module umon_top (
   // Clock and reset
   input  wire        mclk,
   input  wire        resetn,
   // Management register port
   input  wire [8:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [15:0] reg_wdata,
   output reg  [15:0] reg_rdata,
   // Monitored sources (asynchronous)
   input  wire        state_illegal,
   input  wire [9:0]  state_fault_src,
   input  wire [3:0]  ecc_event,
   input  wire        management_lockout,
   input  wire [15:0] temp_sample,
   input  wire [7:0]  phase_diff,
   // Strap options captured into configuration defaults
   input  wire [15:0] strap_value,
   // Upset interrupt pin function select
   input  wire        upset_irq_pin_function,
   // Fault outputs
   output reg         state_fault_irq_n,
   output reg         cfg_fault_irq_n,
   output reg         thermal_jump_irq_n,
   output reg         upset_irq_n,
   output reg         phy_reset_req,
   output reg         cfg_restore
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam SW = 1 + 10 + 4 + 1 + 16 + 8;
   reg  [SW-1:0] sync1_reg;
   reg  [SW-1:0] sync2_reg;
   reg           st_ill_d_reg;
   wire [SW-1:0] raw_in;
   assign raw_in = {state_illegal, state_fault_src, ecc_event, management_lockout,
                    temp_sample, phase_diff};

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= {SW{1'b0}};
         sync2_reg <= {SW{1'b0}};
         st_ill_d_reg <= 1'b0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
         st_ill_d_reg <= sync2_reg[39];
      end
   end

   wire        st_ill_s  = sync2_reg[39];
   wire [9:0]  st_src_s  = sync2_reg[38:29];
   wire [3:0]  ecc_s     = sync2_reg[28:25];
   wire        lock_s    = sync2_reg[24];
   wire [15:0] temp_s    = sync2_reg[23:8];
   wire [7:0]  phase_s   = sync2_reg[7:0];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [15:0] irq_mask_reg;
   reg  [15:0] ecc_ctrl_reg;
   reg  [1:0]  st_mask_reg;
   reg  [9:0]  st_stat_reg;
   reg  [3:0]  ecc_stat_reg;
   reg  [7:0]  lock_win_reg;
   reg  [7:0]  relock_reg;
   reg  [7:0]  therm_pct_reg;
   reg         cfg_fault_reg;
   reg         therm_flag_reg;
   reg         pll_flag_reg;
   reg  [15:0] strap_reg;
   reg         strap_done_reg;

   wire        wr_mask  = reg_wr && (reg_addr == `UMON_ADDR_IRQ_MASK);
   wire        wr_stat  = reg_wr && (reg_addr == `UMON_ADDR_FAULT_STAT);
   wire        wr_ecc   = reg_wr && (reg_addr == `UMON_ADDR_ECC_CTRL);
   wire        wr_thr   = reg_wr && (reg_addr == `UMON_ADDR_TEMP_HI);
   wire        ecc_en   = |ecc_ctrl_reg[`UMON_ECC_EN_HI:`UMON_ECC_EN_LO];
   wire        recover  = ecc_ctrl_reg[`UMON_RECOVER_BIT];
   // Rising edge only, so a held source gives one recovery pulse
   wire        st_event = st_ill_s && !st_ill_d_reg; // R01
   wire [3:0]  ecc_evt  = ecc_en ? ecc_s : 4'h0; // R05
   wire        pll_locked;
   wire        cfg_mismatch;
   wire        therm_jump;

   // Strap level caught once after reset release
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         strap_reg      <= 16'h0000;
         strap_done_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_reg      <= strap_value;
         strap_done_reg <= 1'b1;
      end
   end

   // Configuration words and status flags; set wins over write-one-to-clear
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_mask_reg   <= `UMON_MASK_RESET;
         ecc_ctrl_reg   <= `UMON_ECC_CTRL_RESET;
         st_mask_reg    <= 2'b00;
         st_stat_reg    <= 10'h000;
         ecc_stat_reg   <= 4'h0;
         lock_win_reg   <= `UMON_LOCK_WIN_RESET;
         relock_reg     <= `UMON_RELOCK_RESET;
         therm_pct_reg  <= `UMON_THERM_PCT_RESET;
         cfg_fault_reg  <= 1'b0;
         therm_flag_reg <= 1'b0;
         pll_flag_reg   <= 1'b0;
      end else begin
         if (cfg_mismatch && recover) begin
            irq_mask_reg  <= `UMON_MASK_RESET | strap_reg; // R09
            ecc_ctrl_reg  <= `UMON_ECC_CTRL_RESET;          // R09
            lock_win_reg  <= `UMON_LOCK_WIN_RESET;
            relock_reg    <= `UMON_RELOCK_RESET;
            therm_pct_reg <= `UMON_THERM_PCT_RESET;
         end else begin
            if (wr_mask) begin
               irq_mask_reg <= reg_wdata;
               lock_win_reg <= reg_wdata[7:0];
            end
            if (wr_ecc) begin
               ecc_ctrl_reg <= reg_wdata; // R05
               relock_reg   <= reg_wdata[7:0];
            end
            if (wr_thr)
               therm_pct_reg <= reg_wdata[7:0]; // R10
         end
         if (wr_stat)
            st_mask_reg <= reg_wdata[`UMON_ST_MASK_HI:`UMON_ST_MASK_LO]; // R03
         st_stat_reg  <= (st_stat_reg & ~(wr_stat ? reg_wdata[11:2] : 10'h000))
                         | (st_event ? (st_src_s | 10'h001) : 10'h000); // R01
         ecc_stat_reg <= (ecc_stat_reg & ~(wr_stat ? reg_wdata[15:12] : 4'h0))
                         | ecc_evt; // R04
         cfg_fault_reg  <= cfg_mismatch | (cfg_fault_reg & ~(wr_stat & reg_wdata[15])); // R07
         therm_flag_reg <= therm_jump | (therm_flag_reg & ~(wr_thr & reg_wdata[15]));  // R10
         pll_flag_reg   <= !pll_locked | (pll_flag_reg & ~(wr_mask & reg_wdata[15])); // R12
      end
   end

   // ----------------------------------------
   // Checksum over configuration words
   // ----------------------------------------
   localparam CS_IDLE = 2'b00;
   localparam CS_GOLD = 2'b01;
   localparam CS_RUN  = 2'b10;

   reg  [1:0]  cs_state_reg;
   reg  [1:0]  cs_idx_reg;
   reg  [15:0] cs_acc_reg;
   reg  [15:0] golden_reg;
   reg         golden_ok_reg;
   reg         lock_d_reg;
   reg         por_pend_reg;
   reg         mism_reg;

   function [15:0] cfg_word;
      input [1:0] idx;
      begin
         case (idx)
            2'd0:    cfg_word = irq_mask_reg;
            2'd1:    cfg_word = ecc_ctrl_reg;
            2'd2:    cfg_word = {lock_win_reg, relock_reg};
            default: cfg_word = {8'h00, therm_pct_reg};
         endcase
      end
   endfunction

   wire lock_rise = lock_s && !lock_d_reg;
   wire last_word = (cs_idx_reg == 2'd3);
   wire [15:0] acc_next = cs_acc_reg + cfg_word(cs_idx_reg);
   assign cfg_mismatch = mism_reg;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cs_state_reg  <= CS_IDLE;
         cs_idx_reg    <= 2'd0;
         cs_acc_reg    <= `UMON_SUM_RESET;
         golden_reg    <= `UMON_SUM_RESET;
         golden_ok_reg <= 1'b0;
         lock_d_reg    <= 1'b0;
         por_pend_reg  <= 1'b1;
         mism_reg      <= 1'b0;
      end else begin
         lock_d_reg <= lock_s;
         mism_reg   <= 1'b0;
         if (!lock_s && !por_pend_reg) begin
            golden_reg    <= `UMON_SUM_RESET; // R08
            golden_ok_reg <= 1'b0;            // R08
            cs_state_reg  <= CS_IDLE;
         end else if (lock_rise || por_pend_reg) begin
            por_pend_reg  <= 1'b0;
            golden_ok_reg <= 1'b0;
            cs_state_reg  <= CS_GOLD; // R06
            cs_idx_reg    <= 2'd0;
            cs_acc_reg    <= `UMON_SUM_RESET;
         end else begin
            case (cs_state_reg)
               CS_GOLD: begin
                  cs_idx_reg <= cs_idx_reg + 2'd1;
                  cs_acc_reg <= last_word ? `UMON_SUM_RESET : acc_next;
                  if (last_word) begin
                     golden_reg    <= acc_next; // R06
                     golden_ok_reg <= 1'b1;     // R17
                     cs_state_reg  <= lock_s ? CS_RUN : CS_IDLE;
                  end
               end
               CS_RUN: begin
                  cs_idx_reg <= cs_idx_reg + 2'd1;
                  cs_acc_reg <= last_word ? `UMON_SUM_RESET : acc_next;
                  if (last_word && golden_ok_reg && (acc_next != golden_reg))
                     mism_reg <= 1'b1; // R07 R17
               end
               default: cs_state_reg <= CS_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Thermal jump detection
   // ----------------------------------------
   reg  [15:0] temp_prev_reg;
   reg  [2:0]  temp_vld_reg;
   wire [15:0] temp_delta = (temp_s > temp_prev_reg) ? (temp_s - temp_prev_reg)
                                                     : (temp_prev_reg - temp_s);
   wire [23:0] delta_x100 = {8'h00, temp_delta} * 24'd100;
   wire [23:0] limit      = {8'h00, temp_prev_reg} * {16'h0000, therm_pct_reg};
   // Jumps ignored until the previous sample holds a real reading
   assign therm_jump = temp_vld_reg[2] && (delta_x100 > limit); // R10

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         temp_prev_reg <= 16'h0000;
         temp_vld_reg  <= 3'h0;
      end else begin
         temp_prev_reg <= temp_s;
         temp_vld_reg  <= {temp_vld_reg[1:0], 1'b1};
      end
   end

   // ----------------------------------------
   // PLL lock detector
   // ----------------------------------------
   umon_lock_detect u_lock (
      .mclk          (mclk),
      .resetn        (resetn),
      .phase_diff    (phase_s),
      .delay_window  (lock_win_reg),
      .relock_cycles (relock_reg),
      .locked_reg    (pll_locked)
   );

   // ----------------------------------------
   // Outputs and read mux
   // ----------------------------------------
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_fault_irq_n  <= 1'b1;
         cfg_fault_irq_n    <= 1'b1;
         thermal_jump_irq_n <= 1'b1;
         upset_irq_n        <= 1'b1;
         phy_reset_req      <= 1'b0;
         cfg_restore        <= 1'b0;
         reg_rdata          <= 16'h0000;
      end else begin
         state_fault_irq_n  <= !((|st_stat_reg) && !(&st_mask_reg)); // R01 R02 R03 R18
         cfg_fault_irq_n    <= !(cfg_fault_reg || (|ecc_stat_reg));   // R04 R07 R09 R18
         thermal_jump_irq_n <= !(therm_flag_reg &&
                                 !irq_mask_reg[`UMON_THERM_MASK_BIT]); // R10 R18
         upset_irq_n        <= !(pll_flag_reg && upset_irq_pin_function &&
                                 !irq_mask_reg[`UMON_PLL_MASK_BIT]);  // R12 R15 R16 R18
         phy_reset_req      <= st_event && recover;                   // R02
         cfg_restore        <= cfg_mismatch && recover;               // R09
         if (reg_rd) begin
            case (reg_addr)
               `UMON_ADDR_IRQ_MASK:   reg_rdata <= irq_mask_reg;
               `UMON_ADDR_FAULT_STAT: reg_rdata <= {ecc_stat_reg, st_stat_reg, st_mask_reg};
               `UMON_ADDR_TEMP_LO:    reg_rdata <= temp_s;                   // R11
               `UMON_ADDR_TEMP_HI:    reg_rdata <= {therm_flag_reg, 7'h00, therm_pct_reg}; // R11
               `UMON_ADDR_ECC_CTRL:   reg_rdata <= ecc_ctrl_reg;
               default:               reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

endmodule

//--- sim/umon_properties.sv
// Port-level checks for the upset monitor suite
`timescale 1ns/100ps
module umon_properties (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        resetn,
   // Register port
   input wire logic [8:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   // Sources and fault outputs
   input wire logic        state_illegal,
   input wire logic        upset_irq_pin_function,
   input wire logic        state_fault_irq_n,
   input wire logic        cfg_fault_irq_n,
   input wire logic        upset_irq_n,
   input wire logic        phy_reset_req,
   input wire logic        cfg_restore
);
   logic [1:0] st_mask_reg;
   logic       pll_mask_reg;
   logic       recov_reg;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------
   // Shadow of mask and recovery bits
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_mask_reg  <= 2'h0;
         pll_mask_reg <= 1'b1;
         recov_reg    <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == 9'h1D8) st_mask_reg <= reg_wdata[1:0];
         if (reg_addr == 9'h1D7) pll_mask_reg <= reg_wdata[11];
         if (reg_addr == 9'h1EE) recov_reg <= reg_wdata[15];
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_state_low;
      ##[1:6] !state_fault_irq_n;
   endsequence
   sequence s_cfg_low;
      ##[0:4] !cfg_fault_irq_n;
   endsequence
   a_state_raise: assert property ($rose(state_illegal) && st_mask_reg != 2'h3 |-> s_state_low)
      else $error("state fault pin not driven low");
   a_state_masked: assert property (st_mask_reg == 2'h3 && $past(st_mask_reg) == 2'h3 |-> state_fault_irq_n)
      else $error("masked state fault pin driven low");
   a_reset_gated: assert property (phy_reset_req |-> recov_reg)
      else $error("internal reset without self-recovery");
   a_reset_pulse: assert property (phy_reset_req |=> !phy_reset_req)
      else $error("internal reset longer than one cycle");
   a_restore_gated: assert property (cfg_restore |-> recov_reg)
      else $error("restore without self-recovery");
   a_restore_fault: assert property (cfg_restore |-> s_cfg_low)
      else $error("restore without configuration fault pin");
   a_pll_function: assert property (!upset_irq_pin_function && !$past(upset_irq_pin_function) |-> upset_irq_n)
      else $error("upset pin low without pin function");
   a_pll_masked: assert property (pll_mask_reg && $past(pll_mask_reg) |-> upset_irq_n)
      else $error("masked lock interrupt driven low");
   a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule
bind umon_top umon_properties u_props (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .state_illegal(state_illegal), .upset_irq_pin_function(upset_irq_pin_function),
   .state_fault_irq_n(state_fault_irq_n), .cfg_fault_irq_n(cfg_fault_irq_n),
   .upset_irq_n(upset_irq_n), .phy_reset_req(phy_reset_req), .cfg_restore(cfg_restore));

//--- sim/umon_sys_ctrl.sv
// System controller model: counts fault indications and recovery pulses
`timescale 1ns/100ps
module umon_sys_ctrl (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       resetn,
   // Fault lines and recovery pulses
   input wire logic [3:0] irq_n,
   input wire logic       phy_reset_req,
   input wire logic       cfg_restore
);
   int         cnt [0:5];
   logic [3:0] irq_q;
   // Falling edges of active-low lines, then the two pulses
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_q <= 4'hF;
         for (int i = 0; i < 6; i++) cnt[i] <= 0;
      end else begin
         irq_q <= irq_n;
         for (int i = 0; i < 4; i++) if (irq_q[i] && !irq_n[i]) cnt[i] <= cnt[i] + 1;
         if (phy_reset_req) cnt[4] <= cnt[4] + 1;
         if (cfg_restore) cnt[5] <= cnt[5] + 1;
      end
   end
endmodule

//--- sim/tb.sv
// Self-checking bench for the upset monitor suite
`timescale 1ns/100ps
module tb;
   logic        mclk;
   logic        resetn;
   logic [8:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_wdata;
   wire  [15:0] reg_rdata;
   logic        state_illegal;
   logic [3:0]  ecc_event;
   logic        management_lockout;
   logic [15:0] temp_sample;
   logic [7:0]  phase_diff;
   logic        upset_irq_pin_function;
   wire  [3:0]  irq_n;
   wire         phy_reset_req;
   wire         cfg_restore;
   int          mismatches;
   int          n_compared;
   int          cyc;
   umon_top dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .state_illegal(state_illegal), .state_fault_src(10'h2A4), .ecc_event(ecc_event),
      .management_lockout(management_lockout), .temp_sample(temp_sample),
      .phase_diff(phase_diff), .strap_value(16'h0010),
      .upset_irq_pin_function(upset_irq_pin_function), .state_fault_irq_n(irq_n[0]),
      .cfg_fault_irq_n(irq_n[1]), .thermal_jump_irq_n(irq_n[2]), .upset_irq_n(irq_n[3]),
      .phy_reset_req(phy_reset_req), .cfg_restore(cfg_restore));
   umon_sys_ctrl ctrl (.mclk(mclk), .resetn(resetn), .irq_n(irq_n),
      .phy_reset_req(phy_reset_req), .cfg_restore(cfg_restore));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         close_out();
      end
   end
   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pin(input int i, input logic v, input bit hold);
      int k;
      k = 0;
      while (k < 12 && (hold || irq_n[i] !== v)) begin
         @(posedge mclk);
         #1;
         k++;
         if (hold && irq_n[i] !== v) k = 12;
      end
      chk(16'(irq_n[i]), 16'(v));
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // Holds the asynchronous sources long enough to cross the synchronisers
   task automatic kick(input logic st, input logic [3:0] ecc);
      @(posedge mclk);
      state_illegal <= st;
      ecc_event <= ecc;
      repeat (3) @(posedge mclk);
      state_illegal <= 1'b0;
      ecc_event <= 4'h0;
   endtask
   task automatic close_out();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      resetn = 1'b0;
      reg_addr = 9'h000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
      state_illegal = 1'b0;
      ecc_event = 4'h0;
      management_lockout = 1'b0;
      temp_sample = 16'h03E8;
      phase_diff = 8'h00;
      upset_irq_pin_function = 1'b0;
      mismatches = 0;
      n_compared = 0;
      cyc = 0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      rd(9'h1D7, 16'h0800);
      rd(9'h1D8, 16'h0000);
      rd(9'h1EE, 16'h0000);
      rd(9'h1EA, 16'h000A);
      rd(9'h1E8, 16'h03E8);
      rd(9'h1F0, 16'h0000);
      chk(16'(irq_n), 16'h000F);
      kick(1'b1, 4'h0);
      pin(0, 1'b0, 1'b0);
      rd(9'h1D8, 16'h0A94);
      wr(9'h1D8, 16'h0003);
      pin(0, 1'b1, 1'b0);
      wr(9'h1D8, 16'h0FFC);
      pin(0, 1'b1, 1'b1);
      wr(9'h1EE, 16'h8000);
      kick(1'b1, 4'h0);
      pin(0, 1'b0, 1'b0);
      repeat (4) @(posedge mclk);
      chk(16'(ctrl.cnt[4]), 16'h0001);
      wr(9'h1D8, 16'h0FFC);
      wr(9'h1EE, 16'h0380);
      kick(1'b0, 4'h5);
      pin(1, 1'b0, 1'b0);
      rd(9'h1D8, 16'h5000);
      wr(9'h1D8, 16'hF000);
      pin(1, 1'b1, 1'b0);
      wr(9'h1EE, 16'h8000);
      kick(1'b0, 4'hA);
      pin(1, 1'b1, 1'b1);
      @(posedge mclk);
      management_lockout <= 1'b1;
      pin(1, 1'b1, 1'b1);
      pin(1, 1'b1, 1'b1);
      wr(9'h1EE, 16'h8001);
      pin(1, 1'b0, 1'b0);
      repeat (4) @(posedge mclk);
      chk(16'(ctrl.cnt[5]), 16'h0001);
      rd(9'h1EE, 16'h0000);
      rd(9'h1D7, 16'h0810);
      @(posedge mclk);
      management_lockout <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(9'h1D8, 16'h8000);
      pin(1, 1'b1, 1'b0);
      wr(9'h1EE, 16'h0040);
      pin(1, 1'b1, 1'b1);
      @(posedge mclk);
      temp_sample <= 16'h0460;
      pin(2, 1'b0, 1'b0);
      rd(9'h1EA, 16'h800A);
      wr(9'h1EA, 16'h800A);
      pin(2, 1'b1, 1'b0);
      @(posedge mclk);
      temp_sample <= 16'h0488;
      pin(2, 1'b1, 1'b1);
      wr(9'h1D7, 16'h8804);
      @(posedge mclk);
      upset_irq_pin_function <= 1'b1;
      phase_diff <= 8'h10;
      pin(3, 1'b1, 1'b1);
      wr(9'h1D7, 16'h0004);
      pin(3, 1'b0, 1'b0);
      @(posedge mclk);
      phase_diff <= 8'h00;
      wr(9'h1D7, 16'h8004);
      pin(3, 1'b0, 1'b1);
      repeat (80) @(posedge mclk);
      wr(9'h1D7, 16'h8004);
      pin(3, 1'b1, 1'b0);
      @(posedge mclk);
      upset_irq_pin_function <= 1'b0;
      phase_diff <= 8'h10;
      pin(3, 1'b1, 1'b1);
      chk(16'({ctrl.cnt[1][7:0], ctrl.cnt[0][7:0]}), 16'h0202);
      chk(16'({ctrl.cnt[3][7:0], ctrl.cnt[2][7:0]}), 16'h0101);
      close_out();
   end
endmodule
